// ==== core/ieu_pkg.sv ====
/*
  Shared constants, types and helpers for the instruction execute unit.
  Assumes a single core clock and an APB register bus with 12-bit byte addresses.
*/
package ieu_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses on the APB bus.
  localparam logic [11:0] OFS_INSTR = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_ACC = 12'h008;
  localparam logic [11:0] OFS_STACK = 12'h00c;
  localparam logic [11:0] OFS_WDOG = 12'h010;
  // Data memory window: paddr[11:10] equal to this, byte index in paddr[9:2].
  localparam logic [1:0] RAM_WINDOW = 2'h1;

  // Status register bit positions.
  localparam int unsigned SB_PDF = 4;
  localparam int unsigned SB_TO = 5;
  localparam int unsigned SB_EMI = 6;
  localparam int unsigned SB_HALT = 7;
  localparam int unsigned SB_BUSY = 8;
  localparam int unsigned SB_SP = 12;
  localparam int unsigned SB_PC = 16;

  // Values after reset, the interrupt vector and the stack depth.
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [10:0] PC_RST = 11'h000;
  localparam logic [10:0] IRQ_VECTOR = 11'h004;
  localparam logic [7:0] WDOG_RST = 8'h00;
  localparam logic [3:0] STK_DEPTH = 4'h8;

  // Decimal adjust constants.
  localparam logic [3:0] NIB_MAX = 4'h9;
  localparam logic [7:0] LO_FIX = 8'h06;
  localparam logic [7:0] HI_FIX = 8'h60;

  ////////////////////////////////////////////////////////////////////////////////
  typedef enum logic [4:0] {
    OP_IDLE = 5'h00, OP_INVERT_MEM = 5'h01, OP_INVERT_TO_ACC = 5'h02,
    OP_BCD_ADJUST = 5'h03, OP_MEM_MINUS_ONE = 5'h04, OP_MEM_MINUS_ONE_TO_ACC = 5'h05,
    OP_MEM_PLUS_ONE = 5'h06, OP_MEM_PLUS_ONE_TO_ACC = 5'h07, OP_POWER_DOWN = 5'h08,
    OP_GOTO_ADDR = 5'h09, OP_COPY_MEM_TO_ACC = 5'h0a, OP_COPY_IMM_TO_ACC = 5'h0b,
    OP_COPY_ACC_TO_MEM = 5'h0c, OP_UNION_MEM_TO_ACC = 5'h0d, OP_UNION_IMM_TO_ACC = 5'h0e,
    OP_BITWISE_UNION_TO_MEM = 5'h0f, OP_SUBROUTINE_RETURN = 5'h10,
    OP_RETURN_LOAD_ACC = 5'h11, OP_INTERRUPT_RETURN = 5'h12, OP_ROTATE_UP = 5'h13,
    OP_ROTATE_UP_TO_ACC = 5'h14, OP_ROTATE_UP_VIA_CARRY = 5'h15,
    OP_ROTATE_UP_VIA_CARRY_TO_ACC = 5'h16, OP_ROTATE_DOWN = 5'h17,
    OP_ROTATE_DOWN_TO_ACC = 5'h18, OP_ROTATE_DOWN_VIA_CARRY = 5'h19,
    OP_ROTATE_DOWN_VIA_CARRY_TO_ACC = 5'h1a, OP_SUBTRACT_WITH_BORROW = 5'h1b,
    OP_SUBTRACT_WITH_BORROW_TO_MEM = 5'h1c
  } ieu_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_EXEC = 2'b01, ST_DUMMY = 2'b10, ST_HALT = 2'b11
  } ieu_state_t;

  typedef struct packed {logic ov; logic z; logic ac; logic c;} ieu_flags_t;
  typedef struct packed {ieu_op_t op; logic [7:0] maddr; logic [7:0] imm;} ieu_instr_t;
  typedef struct packed {logic [7:0] value; logic to_acc; logic to_mem;} ieu_result_t;

  // True when an 8-bit result is zero.
  function automatic logic is_zero(input logic [7:0] v);
    return v == 8'h00;
  endfunction

  // Merge write data into an old word under the APB byte strobes.
  function automatic logic [31:0] apply_strb(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old_w & ~m) | (new_w & m);
  endfunction

endpackage

// ==== core/ieu_data_ram.sv ====
/*
  Byte-wide data memory with one write port and two asynchronous read ports.
  Assumes the owner never requests two writes in the same cycle.
*/
module ieu_data_ram
  import ieu_pkg::*;
(
  input wire logic core_clk,
  input wire logic we,
  input wire logic [7:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] raddr_a,
  output logic [7:0] rdata_a,
  input wire logic [7:0] raddr_b,
  output logic [7:0] rdata_b
);

  // Contents survive reset, as data memory does in power down.
  logic [7:0] mem [256];

  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Read ports: execution and bus.
  assign rdata_a = mem[raddr_a];
  assign rdata_b = mem[raddr_b];

endmodule

// ==== core/ieu_alu.sv ====
/*
  Combinational datapath: result, destination and flags of one instruction.
  Assumes operands are stable for the execute cycle; control ops other than OP_RETURN_LOAD_ACC give no write.
*/
module ieu_alu
  import ieu_pkg::*;
(
  input wire ieu_op_t op,
  input wire logic [7:0] acc,
  input wire logic [7:0] mem,
  input wire logic [7:0] imm,
  input wire ieu_flags_t flags,
  output ieu_result_t res,
  output ieu_flags_t flags_out
);

  logic [8:0] diff;
  logic [4:0] lo_diff;
  logic lo_adj;
  logic hi_adj;
  logic [8:0] bcd_sum;

  // Borrow is the inverted carry; the nibble borrow feeds the nibble carry.
  assign diff = {1'b0, acc} - {1'b0, mem} - {8'h00, ~flags.c};
  assign lo_diff = {1'b0, acc[3:0]} - {1'b0, mem[3:0]} - {4'h0, ~flags.c};
  assign lo_adj = (acc[3:0] > NIB_MAX) | flags.ac;
  assign hi_adj = (acc[7:4] > NIB_MAX) | flags.c;
  assign bcd_sum = {1'b0, acc} + {1'b0, (lo_adj ? LO_FIX : 8'h00) | (hi_adj ? HI_FIX : 8'h00)};

  // Flags not named for an instruction keep their value.
  always_comb begin
    res = '{value: 8'h00, to_acc: 1'b0, to_mem: 1'b0};
    flags_out = flags;
    case (op)
      OP_INVERT_MEM, OP_INVERT_TO_ACC: begin
        res.value = ~mem;
      end
      OP_BCD_ADJUST: begin
        res.value = bcd_sum[7:0];
        flags_out.c = hi_adj | bcd_sum[8];
      end
      OP_MEM_MINUS_ONE, OP_MEM_MINUS_ONE_TO_ACC: begin
        res.value = mem - 8'h01;
      end
      OP_MEM_PLUS_ONE, OP_MEM_PLUS_ONE_TO_ACC: begin
        res.value = mem + 8'h01;
      end
      OP_COPY_MEM_TO_ACC: res.value = mem;
      OP_COPY_IMM_TO_ACC, OP_RETURN_LOAD_ACC: res.value = imm;
      OP_COPY_ACC_TO_MEM: res.value = acc;
      OP_UNION_MEM_TO_ACC, OP_BITWISE_UNION_TO_MEM: res.value = acc | mem;
      OP_UNION_IMM_TO_ACC: res.value = acc | imm;
      OP_ROTATE_UP, OP_ROTATE_UP_TO_ACC: res.value = {mem[6:0], mem[7]};
      OP_ROTATE_UP_VIA_CARRY, OP_ROTATE_UP_VIA_CARRY_TO_ACC: begin
        res.value = {mem[6:0], flags.c};
        flags_out.c = mem[7];
      end
      OP_ROTATE_DOWN, OP_ROTATE_DOWN_TO_ACC: res.value = {mem[0], mem[7:1]};
      OP_ROTATE_DOWN_VIA_CARRY, OP_ROTATE_DOWN_VIA_CARRY_TO_ACC: begin
        res.value = {flags.c, mem[7:1]};
        flags_out.c = mem[0];
      end
      OP_SUBTRACT_WITH_BORROW, OP_SUBTRACT_WITH_BORROW_TO_MEM: begin
        res.value = diff[7:0];
        flags_out.c = ~diff[8];
        flags_out.ac = ~lo_diff[4];
        flags_out.ov = (acc[7] ^ mem[7]) & (acc[7] ^ diff[7]);
      end
      default: res.value = 8'h00;
    endcase
    // Destination and zero flag by instruction form.
    case (op)
      OP_INVERT_MEM, OP_BCD_ADJUST, OP_MEM_MINUS_ONE, OP_MEM_PLUS_ONE, OP_COPY_ACC_TO_MEM,
      OP_BITWISE_UNION_TO_MEM, OP_ROTATE_UP, OP_ROTATE_UP_VIA_CARRY, OP_ROTATE_DOWN,
      OP_ROTATE_DOWN_VIA_CARRY, OP_SUBTRACT_WITH_BORROW_TO_MEM: res.to_mem = 1'b1;
      OP_IDLE, OP_POWER_DOWN, OP_GOTO_ADDR, OP_SUBROUTINE_RETURN,
      OP_INTERRUPT_RETURN: res.to_acc = 1'b0;
      default: res.to_acc = 1'b1;
    endcase
    case (op)
      OP_INVERT_MEM, OP_INVERT_TO_ACC, OP_MEM_MINUS_ONE, OP_MEM_MINUS_ONE_TO_ACC,
      OP_MEM_PLUS_ONE, OP_MEM_PLUS_ONE_TO_ACC, OP_UNION_MEM_TO_ACC, OP_UNION_IMM_TO_ACC,
      OP_BITWISE_UNION_TO_MEM, OP_SUBTRACT_WITH_BORROW,
      OP_SUBTRACT_WITH_BORROW_TO_MEM: flags_out.z = is_zero(res.value);
      default: flags_out.z = flags.z;
    endcase
  end

endmodule

// ==== core/ieu_exec_unit.sv ====
/*
  Instruction execute unit of an 8-bit core, driven over APB: a write to the
  instruction register issues one instruction, which then runs on the core.
  Assumes an APB master on core_clk and an interrupt request pin from another
  domain, held high until irq_ack pulses.
*/
module ieu_exec_unit
  import ieu_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic irq_req,
  output logic irq_ack,
  output logic clk_off
);

  ////////////////////////////////////////////////////////////////////////////////
  ieu_state_t state_reg;
  ieu_instr_t instr_reg;
  ieu_flags_t flags_reg;
  ieu_flags_t alu_flags;
  ieu_result_t alu_res;
  logic [7:0] acc_reg;
  logic [10:0] pc_reg;
  logic [10:0] stk_top;
  logic [10:0] stk [8];
  logic [3:0] sp_reg;
  logic emi_reg;
  logic pdf_reg;
  logic to_reg;
  logic [7:0] wdog_pre_reg;
  logic [7:0] wdog_cnt_reg;
  logic irq_meta_reg;
  logic irq_sync_reg;
  logic irq_take;
  logic irq_ack_reg;
  logic [7:0] mem_rd;
  logic [7:0] bus_mem_rd;
  logic ram_we;
  logic [7:0] ram_waddr;
  logic [7:0] ram_wdata;
  logic exec;
  logic cpu_free;
  logic in_ram;
  logic mapped;
  logic wr_fire;
  logic rd_done_reg;
  logic [31:0] prdata_reg;
  logic [31:0] rd_mux;
  logic [31:0] status_word;

  ////////////////////////////////////////////////////////////////////////////////
  // The request pin is asynchronous; only the second stage is read.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq_meta_reg <= 1'b0;
      irq_sync_reg <= 1'b0;
    end else begin
      irq_meta_reg <= irq_req;
      irq_sync_reg <= irq_meta_reg;
    end
  end

  // Interrupts enter only between instructions, so a return lands first.
  assign irq_take = (state_reg == ST_IDLE) && emi_reg && irq_sync_reg;
  assign exec = (state_reg == ST_EXEC);
  assign cpu_free = (state_reg == ST_IDLE) && !irq_take;

  ////////////////////////////////////////////////////////////////////////////////
  // APB decode. Writes stall while an instruction or interrupt entry runs,
  // which keeps bus writes from racing the execute path.
  assign in_ram = (paddr[11:10] == RAM_WINDOW);
  assign mapped = in_ram || (paddr == OFS_INSTR) || (paddr == OFS_STATUS) ||
                  (paddr == OFS_ACC) || (paddr == OFS_STACK) || (paddr == OFS_WDOG);
  assign pready = pwrite ? cpu_free : rd_done_reg;
  assign pslverr = psel && penable && pready && !mapped;
  assign wr_fire = psel && penable && pwrite && pready && mapped;
  assign prdata = prdata_reg;

  assign status_word = {5'h00, pc_reg, sp_reg, 3'h0, (state_reg != ST_IDLE),
                        (state_reg == ST_HALT), emi_reg, to_reg, pdf_reg, flags_reg};

  // Read mux; unmapped addresses read as zero.
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (in_ram) begin
      rd_mux = {24'h000000, bus_mem_rd};
    end else begin
      case (paddr)
        OFS_INSTR: rd_mux = {11'h000, instr_reg};
        OFS_STATUS: rd_mux = status_word;
        OFS_ACC: rd_mux = {24'h000000, acc_reg};
        OFS_STACK: rd_mux = {21'h000000, stk_top};
        OFS_WDOG: rd_mux = {16'h0000, wdog_cnt_reg, wdog_pre_reg};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // Reads answer one cycle into the access phase with registered data.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rd_done_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else if (psel && penable && !pwrite && !rd_done_reg) begin
      rd_done_reg <= 1'b1;
      prdata_reg <= rd_mux;
    end else begin
      rd_done_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer: issue, execute, dummy cycle for counter changes, halt.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (wr_fire && paddr == OFS_INSTR) begin
            state_reg <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          case (instr_reg.op)
            OP_POWER_DOWN: state_reg <= ST_HALT;
            OP_GOTO_ADDR, OP_SUBROUTINE_RETURN, OP_RETURN_LOAD_ACC,
            OP_INTERRUPT_RETURN: state_reg <= ST_DUMMY;
            default: state_reg <= ST_IDLE;
          endcase
        end
        ST_DUMMY: state_reg <= ST_IDLE;
        ST_HALT: begin
          if (irq_sync_reg) begin
            state_reg <= ST_IDLE; // A request wakes the core.
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Issued instruction word.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      instr_reg <= '{op: OP_IDLE, maddr: 8'h00, imm: 8'h00};
    end else if (wr_fire && paddr == OFS_INSTR) begin
      instr_reg <= ieu_instr_t'(pwdata[20:0]);
    end
  end

  ieu_alu u_alu (
    .op(instr_reg.op),
    .acc(acc_reg),
    .mem(mem_rd),
    .imm(instr_reg.imm),
    .flags(flags_reg),
    .res(alu_res),
    .flags_out(alu_flags)
  );

  // Execute path owns the write port; bus writes only come while idle.
  assign ram_we = (exec && alu_res.to_mem) || (wr_fire && in_ram && pstrb[0]);
  assign ram_waddr = exec ? instr_reg.maddr : paddr[9:2];
  assign ram_wdata = exec ? alu_res.value : pwdata[7:0];

  ieu_data_ram u_ram (
    .core_clk(core_clk),
    .we(ram_we),
    .waddr(ram_waddr),
    .wdata(ram_wdata),
    .raddr_a(instr_reg.maddr),
    .rdata_a(mem_rd),
    .raddr_b(paddr[9:2]),
    .rdata_b(bus_mem_rd)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Accumulator.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      acc_reg <= ACC_RST;
    end else if (exec && alu_res.to_acc) begin
      acc_reg <= alu_res.value;
    end else if (wr_fire && paddr == OFS_ACC) begin
      acc_reg <= 8'(apply_strb({24'h000000, acc_reg}, pwdata, pstrb));
    end
  end

  // Status flags and master enable.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      flags_reg <= '{ov: 1'b0, z: 1'b0, ac: 1'b0, c: 1'b0};
      emi_reg <= 1'b0;
    end else if (exec) begin
      flags_reg <= alu_flags;
      if (instr_reg.op == OP_INTERRUPT_RETURN) begin
        emi_reg <= 1'b1;
      end
    end else if (irq_take) begin
      emi_reg <= 1'b0;
    end else if (wr_fire && paddr == OFS_STATUS && pstrb[0]) begin
      flags_reg <= ieu_flags_t'(pwdata[3:0]);
      emi_reg <= pwdata[SB_EMI];
    end
  end

  // Program counter.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pc_reg <= PC_RST;
    end else if (irq_take) begin
      pc_reg <= IRQ_VECTOR;
    end else if (exec) begin
      case (instr_reg.op)
        OP_GOTO_ADDR: pc_reg <= {instr_reg.maddr[2:0], instr_reg.imm};
        OP_SUBROUTINE_RETURN, OP_RETURN_LOAD_ACC,
        OP_INTERRUPT_RETURN: pc_reg <= stk_top;
        OP_POWER_DOWN: pc_reg <= pc_reg + 11'h001;
        default: pc_reg <= pc_reg + 11'h001;
      endcase
    end
  end

  // Return stack; a pop when empty yields the reset address.
  assign stk_top = (sp_reg == 4'h0) ? PC_RST : stk[3'(sp_reg - 4'h1)];

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sp_reg <= 4'h0;
    end else if (exec && (instr_reg.op == OP_SUBROUTINE_RETURN ||
                          instr_reg.op == OP_RETURN_LOAD_ACC ||
                          instr_reg.op == OP_INTERRUPT_RETURN)) begin
      sp_reg <= (sp_reg == 4'h0) ? 4'h0 : sp_reg - 4'h1;
    end else if ((irq_take || (wr_fire && paddr == OFS_STACK)) && sp_reg != STK_DEPTH) begin
      sp_reg <= sp_reg + 4'h1;
    end
  end

  // Stack contents need no reset; the pointer guards every read.
  always_ff @(posedge core_clk) begin
    if (irq_take && sp_reg != STK_DEPTH) begin
      stk[sp_reg[2:0]] <= pc_reg;
    end else if (wr_fire && paddr == OFS_STACK && sp_reg != STK_DEPTH) begin
      stk[sp_reg[2:0]] <= pwdata[10:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog: held while halted, because the system clock is off there.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wdog_pre_reg <= WDOG_RST;
      wdog_cnt_reg <= WDOG_RST;
    end else if (exec && instr_reg.op == OP_POWER_DOWN) begin
      wdog_pre_reg <= WDOG_RST;
      wdog_cnt_reg <= WDOG_RST;
    end else if (state_reg != ST_HALT) begin
      wdog_pre_reg <= wdog_pre_reg + 8'h01;
      if (wdog_pre_reg == 8'hff) begin
        wdog_cnt_reg <= wdog_cnt_reg + 8'h01;
      end
    end
  end

  // Power-down and expiry flags; halt outranks a same-cycle expiry.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pdf_reg <= 1'b0;
      to_reg <= 1'b0;
    end else if (exec && instr_reg.op == OP_POWER_DOWN) begin
      pdf_reg <= 1'b1;
      to_reg <= 1'b0;
    end else if (state_reg != ST_HALT && wdog_pre_reg == 8'hff && wdog_cnt_reg == 8'hff) begin
      to_reg <= 1'b1;
    end
  end

  // Acknowledge pulse for the interrupt source.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq_ack_reg <= 1'b0;
    end else begin
      irq_ack_reg <= irq_take;
    end
  end

  assign irq_ack = irq_ack_reg;
  assign clk_off = (state_reg == ST_HALT);

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  logic [8:0] sbc_ref;
  assign sbc_ref = {1'b0, acc_reg} - {1'b0, mem_rd} - {8'h00, ~flags_reg.c};

  sequence s_dummy_then_idle;
    state_reg == ST_DUMMY ##1 state_reg == ST_IDLE;
  endsequence

  a_goto_two_cycle: assert property (
    exec && instr_reg.op == OP_GOTO_ADDR
    |=> pc_reg == $past({instr_reg.maddr[2:0], instr_reg.imm}) and s_dummy_then_idle)
    else $error("jump did not load target in two cycles");
  a_return_pop: assert property (
    exec && instr_reg.op == OP_RETURN_LOAD_ACC
    |=> pc_reg == $past(stk_top) && acc_reg == $past(instr_reg.imm) && $stable(flags_reg))
    else $error("return with load went wrong");
  a_interrupt_return_enable: assert property (
    exec && instr_reg.op == OP_INTERRUPT_RETURN |=> emi_reg ##1 state_reg == ST_IDLE)
    else $error("interrupt return did not enable");
  a_interrupt_return_pending: assert property (
    state_reg == ST_DUMMY && emi_reg && irq_sync_reg |=> irq_take ##1 pc_reg == IRQ_VECTOR)
    else $error("pending interrupt not serviced first");
  a_halt_flags: assert property (
    exec && instr_reg.op == OP_POWER_DOWN
    |=> pdf_reg && !to_reg && wdog_cnt_reg == 8'h00 && clk_off)
    else $error("halt flags or watchdog wrong");
  a_sbc_flags: assert property (
    exec && instr_reg.op == OP_SUBTRACT_WITH_BORROW
    |=> acc_reg == $past(sbc_ref[7:0]) && flags_reg.c == !$past(sbc_ref[8])
        && flags_reg.z == (acc_reg == 8'h00))
    else $error("subtract with borrow result or carry wrong");
  a_inc_to_acc: assert property (
    exec && instr_reg.op == OP_MEM_PLUS_ONE_TO_ACC
    |=> acc_reg == $past(mem_rd) + 8'h01 && flags_reg.c == $past(flags_reg.c))
    else $error("increment to accumulator wrong");
  a_acc_form_keeps_mem: assert property (
    exec && (instr_reg.op == OP_INVERT_TO_ACC || instr_reg.op == OP_MEM_MINUS_ONE_TO_ACC)
    |-> !ram_we)
    else $error("accumulator form wrote memory");
  a_copy_no_flags: assert property (
    exec && (instr_reg.op == OP_COPY_MEM_TO_ACC || instr_reg.op == OP_IDLE ||
             instr_reg.op == OP_ROTATE_UP) |=> $stable(flags_reg))
    else $error("flags changed on a flagless instruction");
  a_bcd_carry_only: assert property (
    exec && instr_reg.op == OP_BCD_ADJUST
    |-> ram_we ##1 $stable(acc_reg) && flags_reg.z == $past(flags_reg.z)
        && flags_reg.ov == $past(flags_reg.ov))
    else $error("decimal adjust touched more than carry");

endmodule

// ==== test/tb_ieu_exec_unit.sv ====
/*
  Self-checking bench for the execute unit, driven as an APB master.
  Assumes the package and the unit are compiled first; no partner model.
*/
module tb_ieu_exec_unit
  import ieu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] MEM = 12'h440;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic irq_req = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, irq_ack, clk_off, re;
  logic [31:0] prdata, rq;
  int errors = 0;
  int n_checks = 0;

  ieu_exec_unit i_dut (.core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_req(irq_req), .irq_ack(irq_ack),
    .clk_off(clk_off));

  // Core clock, 10 ns period.
  always #5 core_clk = ~core_clk;

  ////////////////////////////////////////
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // One APB transfer. Ready, read data and error are taken at the rising edge that
  // ends the access; only after that edge is the request released.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    logic r;
    r = 1'b0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (int n = 0; n < 300 && r !== 1'b1; n++) begin
      @(posedge core_clk);
      r = pready;
      if (r === 1'b1) begin
        rq = prdata;
        re = pslverr;
      end
    end
    if (r !== 1'b1) begin
      errors++;
      end_sim();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  // Load operands, issue one instruction, then compare acc, memory and flags.
  task automatic oc(input logic [4:0] op, input logic [7:0] im, input logic [7:0] a,
                    input logic [7:0] m, input logic [3:0] f, input logic [7:0] ea,
                    input logic [7:0] em, input logic [3:0] ef);
    apb(1'b1, OFS_ACC, 32'(a));
    apb(1'b1, MEM, 32'(m));
    apb(1'b1, OFS_STATUS, 32'(f));
    apb(1'b1, OFS_INSTR, {11'h000, op, 8'h10, im});
    apb(1'b0, OFS_ACC, 32'h00000000);
    check(32'(rq[7:0]), 32'(ea));
    apb(1'b0, MEM, 32'h00000000);
    check(32'(rq[7:0]), 32'(em));
    apb(1'b0, OFS_STATUS, 32'h00000000);
    check(32'(rq[3:0]), 32'(ef));
  endtask

  ////////////////////////////////////////
  // Data operations; flags are {ov, z, ac, c}, unlisted flags preset to one where useful.
  task automatic t_alu();
    oc(5'h01, 8'h00, 8'h00, 8'hff, 4'hb, 8'h00, 8'h00, 4'hf);
    oc(5'h02, 8'h00, 8'h11, 8'h0f, 4'h4, 8'hf0, 8'h0f, 4'h0);
    oc(5'h03, 8'h00, 8'h15, 8'h00, 4'he, 8'h15, 8'h1b, 4'he);
    oc(5'h03, 8'h00, 8'ha3, 8'h00, 4'h0, 8'ha3, 8'h03, 4'h1);
    oc(5'h03, 8'h00, 8'h33, 8'h00, 4'h3, 8'h33, 8'h99, 4'h3);
    oc(5'h04, 8'h00, 8'h00, 8'h00, 4'h1, 8'h00, 8'hff, 4'h1);
    oc(5'h05, 8'h00, 8'h00, 8'h01, 4'h0, 8'h00, 8'h01, 4'h4);
    oc(5'h06, 8'h00, 8'h00, 8'hff, 4'h0, 8'h00, 8'h00, 4'h4);
    oc(5'h07, 8'h00, 8'h00, 8'h7f, 4'h5, 8'h80, 8'h7f, 4'h1);
    oc(5'h00, 8'h00, 8'h12, 8'h34, 4'h9, 8'h12, 8'h34, 4'h9);
    oc(5'h0a, 8'h00, 8'hff, 8'h00, 4'h0, 8'h00, 8'h00, 4'h0);
    oc(5'h0b, 8'h3c, 8'h00, 8'h55, 4'hf, 8'h3c, 8'h55, 4'hf);
    oc(5'h0c, 8'h00, 8'h00, 8'h55, 4'h0, 8'h00, 8'h00, 4'h0);
    oc(5'h0d, 8'h00, 8'h00, 8'h00, 4'h0, 8'h00, 8'h00, 4'h4);
    oc(5'h0e, 8'h05, 8'h50, 8'h0f, 4'h4, 8'h55, 8'h0f, 4'h0);
    oc(5'h0f, 8'h00, 8'h50, 8'h0a, 4'hb, 8'h50, 8'h5a, 4'hb);
    oc(5'h13, 8'h00, 8'h00, 8'h81, 4'he, 8'h00, 8'h03, 4'he);
    oc(5'h14, 8'h00, 8'h00, 8'h81, 4'he, 8'h03, 8'h81, 4'he);
    oc(5'h15, 8'h00, 8'h00, 8'h81, 4'he, 8'h00, 8'h02, 4'hf);
    oc(5'h16, 8'h00, 8'h00, 8'h01, 4'h1, 8'h03, 8'h01, 4'h0);
    oc(5'h17, 8'h00, 8'h00, 8'h81, 4'he, 8'h00, 8'hc0, 4'he);
    oc(5'h18, 8'h00, 8'h00, 8'h81, 4'he, 8'hc0, 8'h81, 4'he);
    oc(5'h19, 8'h00, 8'h00, 8'h81, 4'he, 8'h00, 8'h40, 4'hf);
    oc(5'h1a, 8'h00, 8'h00, 8'h02, 4'h1, 8'h81, 8'h02, 4'h0);
    oc(5'h1b, 8'h00, 8'h05, 8'h05, 4'h1, 8'h00, 8'h05, 4'h7);
    oc(5'h1b, 8'h00, 8'h05, 8'h05, 4'h0, 8'hff, 8'h05, 4'h0);
    oc(5'h1b, 8'h00, 8'h80, 8'h01, 4'h1, 8'h7f, 8'h01, 4'h9);
    oc(5'h1c, 8'h00, 8'h05, 8'h05, 4'h1, 8'h05, 8'h00, 4'h7);
    $display("data operations done");
  endtask

  // Jump, returns, and a request left pending across an interrupt return.
  task automatic t_flow();
    apb(1'b1, OFS_STATUS, 32'h0000000a);
    apb(1'b1, OFS_INSTR, 32'h00090123);
    apb(1'b0, OFS_STATUS, 32'h00000000);
    check(32'(rq[26:16]), 32'h00000123);
    check(32'(rq[3:0]), 32'h0000000a);
    apb(1'b1, OFS_STACK, 32'h00000055);
    apb(1'b1, OFS_INSTR, 32'h00110077);
    apb(1'b0, OFS_STATUS, 32'h00000000);
    check(32'(rq[26:16]), 32'h00000055);
    apb(1'b0, OFS_ACC, 32'h00000000);
    check(32'(rq[7:0]), 32'h00000077);
    apb(1'b1, OFS_STACK, 32'h00000044);
    apb(1'b1, OFS_INSTR, 32'h00100000);
    apb(1'b0, OFS_STATUS, 32'h00000000);
    check(32'(rq[26:16]), 32'h00000044);
    check(32'(rq[3:0]), 32'h0000000a);
    irq_req <= 1'b1;
    apb(1'b1, OFS_STACK, 32'h00000066);
    apb(1'b1, OFS_INSTR, 32'h00120000);
    for (int n = 0; n < 50 && irq_ack !== 1'b1; n++) @(negedge core_clk);
    check(32'(irq_ack), 32'h00000001);
    if (irq_ack !== 1'b1) end_sim();
    @(posedge core_clk);
    irq_req <= 1'b0;
    apb(1'b0, OFS_STATUS, 32'h00000000);
    check(32'(rq[26:16]), 32'(IRQ_VECTOR));
    apb(1'b0, OFS_STACK, 32'h00000000);
    check(32'(rq[10:0]), 32'h00000066);
    apb(1'b0, 12'h020, 32'h00000000);
    check(32'(re), 32'h00000001);
    $display("control flow done");
  endtask

  // Let the watchdog expire first, so that halt has an expiry flag to clear; then
  // halt, and wake by a request while interrupts stay masked.
  task automatic t_halt();
    for (int n = 0; n < 20000 && rq[SB_TO] !== 1'b1; n++) apb(1'b0, OFS_STATUS, 32'h0);
    check(32'(rq[SB_TO]), 32'h00000001);
    if (rq[SB_TO] !== 1'b1) end_sim();
    apb(1'b1, OFS_INSTR, 32'h00080000);
    apb(1'b0, OFS_STATUS, 32'h00000000);
    check(32'(rq[SB_PDF]), 32'h00000001);
    check(32'(rq[SB_TO]), 32'h00000000);
    check(32'(clk_off), 32'h00000001);
    apb(1'b0, OFS_WDOG, 32'h00000000);
    check(32'(rq[15:0]), 32'h00000000);
    irq_req <= 1'b1;
    for (int n = 0; n < 50 && clk_off !== 1'b0; n++) @(negedge core_clk);
    check(32'(clk_off), 32'h00000000);
    if (clk_off !== 1'b0) end_sim();
    @(posedge core_clk);
    irq_req <= 1'b0;
    $display("halt done");
  endtask

  // Reset for 16 cycles, then the scenarios in turn.
  initial begin
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    t_alu();
    t_flow();
    t_halt();
    end_sim();
  end
endmodule
